// File: core/rswc_params.svh
/*
 * Constants of the radio sleep and wake controller: register word
 * indices, control and interrupt bit positions, reset values, timing.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef RSWC_PARAMS_SVH
`define RSWC_PARAMS_SVH

// ============================================================
// Register word indices
`define RSWC_A_CTRL 4'h0
`define RSWC_A_SCAN 4'h1
`define RSWC_A_SNIFF 4'h2
`define RSWC_A_EVT 4'h3
`define RSWC_A_STAT 4'h4
`define RSWC_A_INTS 4'h5
`define RSWC_A_INTM 4'h6
`define RSWC_A_ATTN 4'h7

// ============================================================
// Control bits
`define RSWC_C_SLEEP_EN 0
`define RSWC_C_WAKE_HIGH 1
`define RSWC_C_HWAKE_HIGH 2
`define RSWC_C_USB_MODE 3
`define RSWC_C_RADIO_OFF 4
`define RSWC_C_SCAN_EN 5
`define RSWC_C_SNIFF_EN 6

// ============================================================
// Interrupt bits
`define RSWC_I_HOSTWAKE 0
`define RSWC_I_TMRWAKE 1
`define RSWC_I_SLEEP 2
`define RSWC_I_EVTDONE 3
`define RSWC_I_RESUME 4
`define RSWC_INT_W 5

// ============================================================
// Reset values and timing
`define RSWC_CTRL_RST 16'h0000
`define RSWC_SCAN_RST 16'h0100
`define RSWC_SNIFF_RST 16'h0200
`define RSWC_EVT_RST 16'h0004
`define RSWC_CLK_MHZ 125
`define RSWC_SETTLE_NS 1000

`endif

// File: core/rswc_pkg.sv
/*
 * Types of the radio sleep and wake controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rswc_pkg;

    typedef logic [15:0] rswc_word_t;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_ASLEEP,
        ST_WARM,
        ST_EVENT
    } rswc_state_e;

endpackage

// File: core/rswc_sleep_ctrl.sv
/*
 * Sleep and wake controller of a radio baseband: wake pins, clock
 * request, RF power-down controls, LOW_POWER_OSCILLATOR timed scan and sniff wakes,
 * register port and interrupt.
 * Assumes one 125 MHz clock, synchronous active-high reset, and a
 * low-power oscillator level input much slower than the clock.
 */
// Design decisions made here: the plain strobed port and the register offsets.
// Notes on behaviour
// - Scan/sniff events wake, then sleep again
// - Periodic wakes timed by LOW_POWER_OSCILLATOR-clocked timers
// - Host wake request honoured any time
// - Host wake during session: stay awake
// - Dropping wake request lets device sleep
// - Host transports idle while asleep
// - Core power kept on during sleep
// - Asserted wake input wakes or holds awake
// - Deasserted wake: sleep only when criteria met
// - Wake polarity selectable, default active low
// - USB mode: wake pin may force radio off
// - Host-wake output asserted when attention needed
// - Host-wake active level software selectable
// - Clock request high while reference needed
// - Low external reset resets the chip
// - Separate TX, RX, PLL, PA power-downs
// - USB suspend, resume and remote wake
`timescale 1ns/1ps
`include "rswc_params.svh"

module rswc_sleep_ctrl (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ext_reset_n_i,
    input wire logic host_to_device_wake_i,
    input wire logic low_power_oscillator_i,
    input wire logic usb_suspend_i,
    input wire logic usb_resume_i,
    input wire logic tx_active_i,
    input wire logic rx_active_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic irq_o,
    output logic device_to_host_wake_o,
    output logic ext_clock_request_o,
    output logic rf_tx_pd_o,
    output logic rf_rx_pd_o,
    output logic rf_pll_pd_o,
    output logic rf_pa_pd_o,
    output logic transport_idle_o,
    output logic aux_clk_en_o,
    output logic core_power_keep_o,
    output logic radio_off_o,
    output logic usb_remote_wake_o,
    output logic chip_reset_o,
    output logic asleep_o
);

    localparam int SETTLE_CYC = (`RSWC_SETTLE_NS * `RSWC_CLK_MHZ + 999) / 1000;

    // ============================================================
    // Shared timer step: returns {due, next count}
    function automatic logic [16:0] tmr_step(input logic [15:0] cnt, per,
                                             input logic en, tick);
        logic [16:0] r;
        r = {1'b0, cnt};
        if (!en) begin
            r = {1'b0, per};
        end else if (tick) begin
            r = cnt <= 16'h0001 ? {1'b1, per} : {1'b0, cnt - 16'h0001};
        end
        return r;
    endfunction

    // ============================================================
    // Synchronisers
    logic rst_s1_q, rst_s2_q, wake_s1_q, wake_s2_q, rst;
    logic lpo_s1_q, lpo_s2_q, lpo_s3_q, resume_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            chip_reset_o <= 1'b1;
        end else begin
            rst_s1_q <= ~ext_reset_n_i;
            rst_s2_q <= rst_s1_q;
            chip_reset_o <= rst_s2_q;
        end
    end

    assign rst = reset_i | rst_s2_q;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            lpo_s1_q <= 1'b0;
            lpo_s2_q <= 1'b0;
            lpo_s3_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            wake_s1_q <= host_to_device_wake_i;
            wake_s2_q <= wake_s1_q;
            lpo_s1_q <= low_power_oscillator_i;
            lpo_s2_q <= lpo_s1_q;
            lpo_s3_q <= lpo_s2_q;
            resume_q <= usb_resume_i;
        end
    end

    // ============================================================
    // Registers
    rswc_pkg::rswc_word_t ctrl_q, scan_per_q, sniff_per_q, evt_len_q;
    logic [`RSWC_INT_W-1:0] int_st_q, int_mask_q, int_set;
    logic attn_q;
    rswc_pkg::rswc_state_e state_q;

    logic lpo_tick, wake_pin, wake_req, radio_off_req, attn;
    logic usb_mode, sleep_ok, pend_q, host_woke_q;
    logic [15:0] scan_cnt_q, sniff_cnt_q, evt_cnt_q;
    logic [16:0] scan_nx, sniff_nx;
    logic [7:0] settle_q;
    logic evt_done;

    assign lpo_tick = lpo_s2_q & ~lpo_s3_q;
    assign usb_mode = ctrl_q[`RSWC_C_USB_MODE];
    // Pin level equal to the selected active level means asserted
    assign wake_pin = wake_s2_q == ctrl_q[`RSWC_C_WAKE_HIGH];
    assign radio_off_req = usb_mode & ctrl_q[`RSWC_C_RADIO_OFF]
                           & wake_pin;
    // In radio-off use the pin no longer asks for wake
    assign wake_req = wake_pin & ~(usb_mode
                      & ctrl_q[`RSWC_C_RADIO_OFF]);
    assign attn = attn_q | (|(int_st_q & int_mask_q));

    always_ff @(posedge clk_i) begin
        if (rst) begin
            ctrl_q <= `RSWC_CTRL_RST;
            scan_per_q <= `RSWC_SCAN_RST;
            sniff_per_q <= `RSWC_SNIFF_RST;
            evt_len_q <= `RSWC_EVT_RST;
            int_mask_q <= '0;
            attn_q <= 1'b0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `RSWC_A_CTRL: ctrl_q <= reg_wdata_i;
                `RSWC_A_SCAN: scan_per_q <= reg_wdata_i;
                `RSWC_A_SNIFF: sniff_per_q <= reg_wdata_i;
                `RSWC_A_EVT: evt_len_q <= reg_wdata_i;
                `RSWC_A_INTM: int_mask_q <= reg_wdata_i[`RSWC_INT_W-1:0];
                `RSWC_A_ATTN: attn_q <= reg_wdata_i[0];
                default: ;
            endcase
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst) begin
            int_st_q <= '0;
        end else if (reg_wr_i && reg_addr_i == `RSWC_A_INTS) begin
            int_st_q <= (int_st_q & ~reg_wdata_i[`RSWC_INT_W-1:0])
                        | int_set;
        end else begin
            int_st_q <= int_st_q | int_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst || !reg_rd_i) begin
            reg_rdata_o <= '0;
        end else begin
            unique case (reg_addr_i)
                `RSWC_A_CTRL: reg_rdata_o <= ctrl_q;
                `RSWC_A_SCAN: reg_rdata_o <= scan_per_q;
                `RSWC_A_SNIFF: reg_rdata_o <= sniff_per_q;
                `RSWC_A_EVT: reg_rdata_o <= evt_len_q;
                `RSWC_A_STAT: reg_rdata_o <= {11'h000, wake_req, pend_q,
                                              attn, state_q};
                `RSWC_A_INTS: reg_rdata_o <= {11'h000, int_st_q};
                `RSWC_A_INTM: reg_rdata_o <= {11'h000, int_mask_q};
                `RSWC_A_ATTN: reg_rdata_o <= {15'h0000, attn_q};
                default: reg_rdata_o <= '0;
            endcase
        end
    end

    // ============================================================
    // LOW_POWER_OSCILLATOR timers for scan and sniff sessions
    assign scan_nx = tmr_step(scan_cnt_q, scan_per_q,
                              ctrl_q[`RSWC_C_SCAN_EN], lpo_tick);
    assign sniff_nx = tmr_step(sniff_cnt_q, sniff_per_q,
                               ctrl_q[`RSWC_C_SNIFF_EN], lpo_tick);

    always_ff @(posedge clk_i) begin
        if (rst) begin
            scan_cnt_q <= `RSWC_SCAN_RST;
            sniff_cnt_q <= `RSWC_SNIFF_RST;
        end else begin
            scan_cnt_q <= scan_nx[15:0];
            sniff_cnt_q <= sniff_nx[15:0];
        end
    end

    // Pending event; served awake it needs no wake-up
    always_ff @(posedge clk_i) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (scan_nx[16] | sniff_nx[16]) begin
            pend_q <= 1'b1;
        end else if (state_q == rswc_pkg::ST_AWAKE
                     || state_q == rswc_pkg::ST_EVENT) begin
            pend_q <= 1'b0;
        end
    end

    // ============================================================
    // Sleep sequencer
    assign sleep_ok = ctrl_q[`RSWC_C_SLEEP_EN] & ~wake_req & ~attn
                      & ~pend_q & ~tx_active_i & ~rx_active_i
                      & (~usb_mode | usb_suspend_i);
    assign evt_done = state_q == rswc_pkg::ST_EVENT
                      && evt_cnt_q == 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            state_q <= rswc_pkg::ST_AWAKE;
            host_woke_q <= 1'b0;
            settle_q <= '0;
            evt_cnt_q <= '0;
        end else begin
            unique case (state_q)
                rswc_pkg::ST_AWAKE: begin
                    if (sleep_ok) begin
                        state_q <= rswc_pkg::ST_ASLEEP;
                    end
                end
                rswc_pkg::ST_ASLEEP: begin
                    if (wake_req || (usb_mode && !usb_suspend_i)) begin
                        state_q <= rswc_pkg::ST_WARM;
                        host_woke_q <= 1'b1;
                        settle_q <= 8'(SETTLE_CYC);
                    end else if (pend_q) begin
                        state_q <= rswc_pkg::ST_WARM;
                        host_woke_q <= 1'b0;
                        settle_q <= 8'(SETTLE_CYC);
                    end
                end
                rswc_pkg::ST_WARM: begin
                    // Reference clock must settle before use
                    if (settle_q <= 8'h01) begin
                        if (host_woke_q || wake_req) begin
                            state_q <= rswc_pkg::ST_AWAKE;
                        end else begin
                            state_q <= rswc_pkg::ST_EVENT;
                            evt_cnt_q <= evt_len_q;
                        end
                    end else begin
                        settle_q <= settle_q - 8'h01;
                    end
                end
                rswc_pkg::ST_EVENT: begin
                    if (evt_done) begin
                        // Host asked meanwhile: stay up for the session
                        state_q <= wake_req ? rswc_pkg::ST_AWAKE
                                            : rswc_pkg::ST_ASLEEP;
                    end else if (lpo_tick) begin
                        evt_cnt_q <= evt_cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Interrupt events
    always_comb begin
        int_set = '0;
        int_set[`RSWC_I_HOSTWAKE] = state_q == rswc_pkg::ST_ASLEEP
                                    && wake_req;
        int_set[`RSWC_I_TMRWAKE] = state_q == rswc_pkg::ST_ASLEEP
                                   && !wake_req && pend_q;
        int_set[`RSWC_I_SLEEP] = (state_q == rswc_pkg::ST_AWAKE
                                  && sleep_ok) || (evt_done && !wake_req);
        int_set[`RSWC_I_EVTDONE] = evt_done;
        int_set[`RSWC_I_RESUME] = usb_mode && usb_resume_i
                                  && !resume_q;
    end

    // ============================================================
    // Registered outputs
    logic asleep_nx, rf_off;
    assign asleep_nx = state_q == rswc_pkg::ST_ASLEEP;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            irq_o <= 1'b0;
            device_to_host_wake_o <= 1'b1;
            usb_remote_wake_o <= 1'b0;
        end else begin
            irq_o <= |(int_st_q & int_mask_q);
            device_to_host_wake_o <= attn
                == ctrl_q[`RSWC_C_HWAKE_HIGH];
            // Remote wake only toward a suspended host bus
            usb_remote_wake_o <= usb_mode & usb_suspend_i & attn;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst) begin
            ext_clock_request_o <= 1'b1;
            transport_idle_o <= 1'b0;
            aux_clk_en_o <= 1'b1;
            asleep_o <= 1'b0;
            radio_off_o <= 1'b0;
            core_power_keep_o <= 1'b1;
        end else begin
            ext_clock_request_o <= ~asleep_nx;
            transport_idle_o <= asleep_nx;
            aux_clk_en_o <= ~asleep_nx;
            asleep_o <= asleep_nx;
            radio_off_o <= radio_off_req;
            // Core rail never drops, so registers and RAM survive sleep
            core_power_keep_o <= 1'b1;
        end
    end

    // Radio off or asleep forces every path down
    assign rf_off = asleep_nx | radio_off_req
                    | state_q == rswc_pkg::ST_WARM;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            rf_tx_pd_o <= 1'b1;
            rf_rx_pd_o <= 1'b1;
            rf_pll_pd_o <= 1'b1;
            rf_pa_pd_o <= 1'b1;
        end else begin
            rf_tx_pd_o <= rf_off | ~tx_active_i;
            rf_rx_pd_o <= rf_off | ~rx_active_i;
            rf_pll_pd_o <= rf_off | ~(tx_active_i | rx_active_i);
            rf_pa_pd_o <= rf_off | ~tx_active_i;
        end
    end

    // ============================================================
    // Assertions
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst);

    sequence s_sleep_req;
        state_q == rswc_pkg::ST_AWAKE && sleep_ok;
    endsequence
    sequence s_now_asleep;
        state_q == rswc_pkg::ST_ASLEEP ##1 transport_idle_o;
    endsequence
    a_enter_sleep: assert property (s_sleep_req |=> s_now_asleep)
        else $error("sleep not entered when allowed");
    a_host_wake: assert property (
        state_q == rswc_pkg::ST_ASLEEP && wake_req |=> state_q ==
        rswc_pkg::ST_WARM ##[1:130] state_q == rswc_pkg::ST_AWAKE)
        else $error("host wake not honoured");
    a_timer_wake: assert property (
        state_q == rswc_pkg::ST_ASLEEP && pend_q && !wake_req
        && !usb_mode |=> state_q == rswc_pkg::ST_WARM)
        else $error("timer event did not wake");
    a_event_back: assert property (
        evt_done |=> state_q == ($past(wake_req) ? rswc_pkg::ST_AWAKE
                                                 : rswc_pkg::ST_ASLEEP))
        else $error("wrong state after event");
    a_awake_held: assert property (
        state_q == rswc_pkg::ST_AWAKE && wake_req
        |=> state_q == rswc_pkg::ST_AWAKE)
        else $error("slept with wake asserted");
    a_sleep_quiet: assert property (
        state_q == rswc_pkg::ST_ASLEEP
        |=> !ext_clock_request_o && !aux_clk_en_o && core_power_keep_o)
        else $error("clocks or power wrong in sleep");
    a_rf_down: assert property (
        state_q == rswc_pkg::ST_ASLEEP
        |=> rf_tx_pd_o && rf_rx_pd_o && rf_pll_pd_o && rf_pa_pd_o)
        else $error("rf powered in sleep");
    a_hwake_level: assert property (
        1'b1 |=> device_to_host_wake_o ==
        ($past(attn) == $past(ctrl_q[`RSWC_C_HWAKE_HIGH])))
        else $error("host wake level wrong");
    a_radio_off: assert property (radio_off_req |=> radio_off_o)
        else $error("radio off not applied");
    a_ext_reset: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !ext_reset_n_i |=> ##2 chip_reset_o)
        else $error("external reset not passed on");

endmodule // rswc_sleep_ctrl

// File: test/rswc_host_model.sv
/*
 * Host-side model: drives the device wake pin at the chosen polarity,
 * makes the low-power oscillator and follows the host-wake output.
 * Assumes the bench clock and reset; the oscillator runs through sleep.
 */
`timescale 1ns/1ps

module rswc_host_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wake_req_i,
    input wire logic wake_high_i,
    input wire logic host_wake_high_i,
    input wire logic device_to_host_wake_i,
    output logic host_to_device_wake_o,
    output logic low_power_oscillator_o,
    output logic host_awake_o
);
    logic [3:0] lpo_div_q;

    // ============================================================
    // Wake pin
    // Request may come at any moment, asleep or not
    always_ff @(posedge clk_i) begin
        host_to_device_wake_o <= wake_high_i ? wake_req_i
                                             : !wake_req_i;
    end

    // ============================================================
    // Slow oscillator
    // Period of 32 bench cycles; never gated, so sleep timers keep going
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lpo_div_q <= 4'h0;
            low_power_oscillator_o <= 1'b0;
        end else begin
            lpo_div_q <= lpo_div_q + 4'h1;
            if (lpo_div_q == 4'hF) begin
                low_power_oscillator_o <= !low_power_oscillator_o;
            end
        end
    end

    // ============================================================
    // Host power state
    // Stays up while asked, sleeps as soon as released
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_awake_o <= 1'b1;
        end else begin
            host_awake_o <= device_to_host_wake_i
                            == host_wake_high_i;
        end
    end
endmodule // rswc_host_model

// File: test/tb_radio_sleep_wake_control.sv
/*
 * Self-checking bench of the radio sleep and wake controller.
 * Assumes the design under core/ and the host model under test/.
 */
`timescale 1ns/1ps
`include "rswc_params.svh"

module tb_radio_sleep_wake_control;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    logic wake_req = 1'b0, wake_high = 1'b0, host_wake_high = 1'b0;
    logic usb_suspend = 1'b0, usb_resume = 1'b0;
    logic tx_active = 1'b0, rx_active = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] rdata;
    logic irq, dth_wake, clk_req, tx_pd, rx_pd, pll_pd, pa_pd, idle, aux;
    logic core_keep, radio_off, remote_wake, chip_reset, asleep;
    logic pin_wake, low_power_oscillator, host_awake;
    int miscompares = 0;
    int n_tests = 0;
    logic [3:0] ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8};
    logic [15:0] rv [6] = '{`RSWC_CTRL_RST, `RSWC_SCAN_RST,
        `RSWC_SNIFF_RST, `RSWC_EVT_RST, 16'h0000, 16'h0000};

    always #4 clk = ~clk;

    rswc_host_model host (.clk_i(clk), .reset_i(reset),
        .wake_req_i(wake_req), .wake_high_i(wake_high),
        .host_wake_high_i(host_wake_high),
        .device_to_host_wake_i(dth_wake), .host_to_device_wake_o(pin_wake),
        .low_power_oscillator_o(low_power_oscillator), .host_awake_o(host_awake));

    rswc_sleep_ctrl DUT (.clk_i(clk), .reset_i(reset),
        .ext_reset_n_i(ext_reset_n), .host_to_device_wake_i(pin_wake),
        .low_power_oscillator_i(low_power_oscillator), .usb_suspend_i(usb_suspend),
        .usb_resume_i(usb_resume), .tx_active_i(tx_active),
        .rx_active_i(rx_active), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(rdata), .irq_o(irq), .device_to_host_wake_o(dth_wake),
        .ext_clock_request_o(clk_req), .rf_tx_pd_o(tx_pd),
        .rf_rx_pd_o(rx_pd), .rf_pll_pd_o(pll_pd), .rf_pa_pd_o(pa_pd),
        .transport_idle_o(idle), .aux_clk_en_o(aux),
        .core_power_keep_o(core_keep), .radio_off_o(radio_off),
        .usb_remote_wake_o(remote_wake), .chip_reset_o(chip_reset),
        .asleep_o(asleep));

    // ============================================================
    // Access and check tasks
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait on the sleep flag; the caller compares afterwards
    task automatic wait_sleep(input logic v, input int lim);
        int i;
        i = 0;
        while (asleep !== v && i < lim) begin
            cycles(1);
            i++;
        end
    endtask

    // Counts cycles in which the device was found asleep
    task automatic naps(input int n, output logic [15:0] cnt);
        cnt = 16'h0000;
        repeat (n) begin
            cycles(1);
            if (asleep !== 1'b0) cnt++;
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ============================================================
    // Watchdog
    // Whole sequence needs well under 15000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // ============================================================
    // Sequence
    initial begin
        logic [15:0] v;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            reg_read(ra[i], v);
            chk("reset value", v, rv[i]);
        end
        chk("host wake idle", 16'(dth_wake), 16'h0001);
        reg_write(`RSWC_A_CTRL, 16'h0001);
        wait_sleep(1'b1, 50);
        chk("sleep entry", 16'(asleep), 16'h0001);
        chk("transport idle", 16'(idle), 16'h0001);
        chk("clock request", 16'(clk_req), 16'h0000);
        chk("core power", {aux, core_keep}, 16'h0001);
        chk("rf power down", {tx_pd, rx_pd, pll_pd, pa_pd}, 16'h000F);
        reg_read(`RSWC_A_STAT, v);
        chk("state asleep", v & 16'h0003, 16'h0001);
        // Low pin demands wake by default
        wake_req <= 1'b1;
        wait_sleep(1'b0, 200);
        chk("host wake", 16'(asleep), 16'h0000);
        chk("clock request", 16'(clk_req), 16'h0001);
        naps(300, v);
        chk("held awake", v, 16'h0000);
        tx_active <= 1'b1;
        wake_req <= 1'b0;
        wake_high <= 1'b1;
        reg_write(`RSWC_A_CTRL, 16'h0003);
        naps(300, v);
        chk("busy tx", v, 16'h0000);
        tx_active <= 1'b0;
        rx_active <= 1'b1;
        naps(200, v);
        chk("busy rx", v, 16'h0000);
        rx_active <= 1'b0;
        wait_sleep(1'b1, 50);
        chk("release sleeps", 16'(asleep), 16'h0001);
        wake_req <= 1'b1;
        wait_sleep(1'b0, 200);
        chk("high polarity", 16'(asleep), 16'h0000);
        wake_req <= 1'b0;
        // Warm-up runs its full settle time before sleep is allowed
        wait_sleep(1'b1, 200);
        chk("high release", 16'(asleep), 16'h0001);
        reg_write(`RSWC_A_SCAN, 16'h0004);
        reg_write(`RSWC_A_SNIFF, 16'h0004);
        reg_write(`RSWC_A_EVT, 16'h0002);
        reg_write(`RSWC_A_INTS, 16'h001F);
        // Scan, then sniff: each must wake on its own and sleep again
        for (int i = 0; i < 2; i++) begin
            reg_write(`RSWC_A_CTRL, i == 0 ? 16'h0023 : 16'h0043);
            wait_sleep(1'b0, 1000);
            chk("timed wake", 16'(asleep), 16'h0000);
            wait_sleep(1'b1, 1000);
            chk("timed resleep", 16'(asleep), 16'h0001);
        end
        reg_read(`RSWC_A_INTS, v);
        chk("timer events", v & 16'h000A, 16'h000A);
        wake_req <= 1'b1;
        // Pin needs a few cycles to reach the sequencer
        cycles(4);
        wait_sleep(1'b0, 1000);
        naps(1500, v);
        chk("session awake", v, 16'h0000);
        wake_req <= 1'b0;
        wait_sleep(1'b1, 1000);
        chk("session resleep", 16'(asleep), 16'h0001);
        reg_write(`RSWC_A_CTRL, 16'h0003);
        reg_read(`RSWC_A_INTS, v);
        chk("sleep event", v & 16'h0004, 16'h0004);
        chk("masked irq", 16'(irq), 16'h0000);
        reg_write(`RSWC_A_INTM, 16'h0004);
        cycles(5);
        chk("irq", 16'(irq), 16'h0001);
        chk("host wake low", 16'(dth_wake), 16'h0000);
        chk("host up", 16'(host_awake), 16'h0001);
        reg_write(`RSWC_A_INTS, 16'h0004);
        cycles(5);
        chk("irq cleared", {irq, dth_wake}, 16'h0001);
        chk("host down", 16'(host_awake), 16'h0000);
        host_wake_high <= 1'b1;
        reg_write(`RSWC_A_CTRL, 16'h0007);
        cycles(3);
        chk("host wake high idle", 16'(dth_wake), 16'h0000);
        reg_write(`RSWC_A_ATTN, 16'h0001);
        cycles(5);
        chk("attention", {dth_wake, host_awake}, 16'h0003);
        reg_write(`RSWC_A_ATTN, 16'h0000);
        reg_write(`RSWC_A_INTM, 16'h0000);
        reg_write(`RSWC_A_CTRL, 16'h001A);
        wake_req <= 1'b1;
        cycles(6);
        chk("radio off", 16'(radio_off), 16'h0001);
        wake_req <= 1'b0;
        reg_write(`RSWC_A_CTRL, 16'h000A);
        usb_suspend <= 1'b1;
        reg_write(`RSWC_A_ATTN, 16'h0001);
        cycles(3);
        chk("remote wake", 16'(remote_wake), 16'h0001);
        reg_write(`RSWC_A_ATTN, 16'h0000);
        cycles(3);
        chk("remote wake off", 16'(remote_wake), 16'h0000);
        usb_resume <= 1'b1;
        cycles(4);
        reg_read(`RSWC_A_INTS, v);
        chk("usb resume", v & 16'h0010, 16'h0010);
        @(posedge clk);
        ext_reset_n <= 1'b0;
        cycles(1);
        chk("reset sync", 16'(chip_reset), 16'h0000);
        cycles(4);
        chk("chip reset", 16'(chip_reset), 16'h0001);
        ext_reset_n <= 1'b1;
        cycles(10);
        reg_read(`RSWC_A_CTRL, v);
        chk("ctrl after reset", v, `RSWC_CTRL_RST);
        stop_test();
    end
endmodule // tb_radio_sleep_wake_control
